// *** shared/irq_rc_defines.svh ***
`ifndef IRQ_RC_DEFINES_SVH
`define IRQ_RC_DEFINES_SVH

// register byte addresses (word aligned)
`define ADDR_PIN_IRQ_SC 12'h000
`define ADDR_RESET_CAUSE 12'h004

// pin_irq_status_control fields
`define BIT_PULL_DISABLE 6
`define BIT_EDGE_POL 5
`define BIT_PIN_EN 4
`define BIT_PIN_FLAG 3
`define BIT_PIN_ACK 2
`define BIT_PIN_IE 1
`define BIT_DETECT_MODE 0
`define PIN_IRQ_SC_RESET 8'h00

// reset_cause_status fields
`define BIT_RC_POWER_ON 7
`define BIT_RC_PIN 6
`define BIT_RC_WATCHDOG 5
`define BIT_RC_BAD_OPCODE 4
`define BIT_RC_BAD_ADDRESS 3
`define BIT_RC_LOW_VOLTAGE 1
`define RESET_CAUSE_MASK 8'hfa

`endif

// *** shared/irq_rc_pkg.sv ***
package irq_rc_pkg;
	typedef logic [7:0] reg8_t;
	typedef enum logic [1:0] {
		HTRANS_IDLE = 2'b00,
		HTRANS_BUSY = 2'b01,
		HTRANS_NONSEQ = 2'b10,
		HTRANS_SEQ = 2'b11
	} htrans_e;
endpackage

// *** src/pin_sync_detect.sv ***
`timescale 1ns/1ps
`include "irq_rc_defines.svh"

module pin_sync_detect #(
	parameter int SYNC_STAGES = 2
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic pin_in,
	input wire logic enable,
	input wire logic polarity,
	input wire logic level_mode,
	output logic event_pulse,
	output logic asserted_level
);
	initial begin
		if (SYNC_STAGES < 2)
			$error("pin_sync_detect needs at least two stages");
	end

	logic [SYNC_STAGES-1:0] sync_r;
	logic prev_r;
	wire logic pin_s = sync_r[SYNC_STAGES-1];
	// polarity folded in so one detector serves both senses
	wire logic active_now = polarity ? pin_s : ~pin_s;
	wire logic active_prev = polarity ? prev_r : ~prev_r;

	// first stage feeds only the next stage
	always_ff @(posedge hclk or negedge hresetn) begin
		// idle high like the pulled-up pin, so no false edge after reset
		if (!hresetn)
			sync_r <= '1;
		else
			sync_r <= {sync_r[SYNC_STAGES-2:0], pin_in}; // RULE20
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			prev_r <= 1'b1;
		else
			prev_r <= pin_s;
	end

	assign asserted_level = enable & level_mode & active_now; // RULE9
	// edge seen once per transition after the synchroniser
	assign event_pulse = enable & ((active_now & ~active_prev) // RULE4
		| asserted_level); // RULE2
endmodule

// *** src/reset_cause_capture.sv ***
`timescale 1ns/1ps
`include "irq_rc_defines.svh"

module reset_cause_capture (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic cause_power_on,
	input wire logic cause_pin,
	input wire logic cause_watchdog,
	input wire logic watchdog_enable,
	input wire logic cause_bad_opcode,
	input wire logic cause_bad_address,
	input wire logic cause_low_voltage,
	input wire logic debug_force_reset_bit,
	output irq_rc_pkg::reg8_t cause_r
);
	logic captured_r;
	irq_rc_pkg::reg8_t snap;

	// causes are sampled at the first edge after release; they are
	// required to hold until then, an async reset may not load them
	always_comb begin
		snap = 8'h00;
		snap[`BIT_RC_POWER_ON] = cause_power_on; // RULE14
		snap[`BIT_RC_PIN] = cause_pin; // RULE15
		snap[`BIT_RC_WATCHDOG] = cause_watchdog & watchdog_enable; // RULE16
		snap[`BIT_RC_BAD_OPCODE] = cause_bad_opcode; // RULE17
		snap[`BIT_RC_BAD_ADDRESS] = cause_bad_address; // RULE18
		snap[`BIT_RC_LOW_VOLTAGE] = cause_low_voltage
			| cause_power_on; // RULE13 RULE19
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			captured_r <= 1'b0;
		else
			captured_r <= 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cause_r <= 8'h00;
		else if (debug_force_reset_bit)
			cause_r <= 8'h00; // RULE11
		else if (!captured_r)
			cause_r <= snap & `RESET_CAUSE_MASK; // RULE10
	end
endmodule

// *** src/ext_irq_and_reset_cause.sv ***
`timescale 1ns/1ps
`include "irq_rc_defines.svh"
// Summary of operation
// RULE1 - pull disable bit turns off pin pull
// RULE2 - polarity bit: 0 falling/low, 1 rising/high
// RULE3 - rising polarity makes pull a pulldown
// RULE4 - pin enable bit gates all pin events
// RULE5 - event flag set on qualifying pin event
// RULE6 - ack write of 1 clears flag; reads 0
// RULE7 - level mode: ack blocked while pin asserted
// RULE8 - interrupt enable drives request from flag
// RULE9 - mode bit: edge only or edge and level
// RULE10 - cause flags at bits 7,6,5,4,3,1
// RULE11 - debug forced reset clears all cause flags
// RULE12 - cause register write restarts watchdog only
// RULE13 - power-on sets power-on and low-voltage flags
// RULE14 - active sources set, inactive cleared at entry
// RULE15 - pin flag marks external reset pin
// RULE16 - watchdog flag only when watchdog enabled
// RULE17 - bad opcode flag marks illegal instruction
// RULE18 - bad address flag marks unmapped access
// RULE19 - low-voltage flag after trip or power-on
// RULE20 - pin passes two flip-flops before detection

module ext_irq_and_reset_cause #(
	parameter int ADDR_W = 12,
	parameter int SYNC_STAGES = 2
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic irq_pin,
	output logic pull_enable,
	output logic pull_is_down,
	output logic pin_irq_request,
	output logic watchdog_restart,
	input wire logic cause_power_on,
	input wire logic cause_pin,
	input wire logic cause_watchdog,
	input wire logic watchdog_enable,
	input wire logic cause_bad_opcode,
	input wire logic cause_bad_address,
	input wire logic cause_low_voltage,
	input wire logic debug_force_reset_bit
);
	initial begin
		if (ADDR_W < 3)
			$error("address too narrow for register map");
	end

	// control bits held separately; flag and ack live in their own logic
	logic pull_disable_r;
	logic edge_polarity_select_r;
	logic pin_function_enable_r;
	logic pin_interrupt_enable_r;
	logic detect_mode_select_r;
	logic pin_event_flag_r;
	logic wr_pend_r;
	logic [ADDR_W-1:0] wr_addr_r;
	logic restart_r;
	logic [31:0] hrdata_r;
	irq_rc_pkg::reg8_t cause_r;

	wire logic pin_event;
	wire logic pin_asserted;

	wire logic addr_phase = hsel & hready & htrans[1];
	wire logic rd_take = addr_phase & ~hwrite;
	wire logic wr_take = addr_phase & hwrite;
	wire logic hit_sc_rd = haddr == ADDR_W'(`ADDR_PIN_IRQ_SC);
	wire logic hit_rc_rd = haddr == ADDR_W'(`ADDR_RESET_CAUSE);
	wire logic wr_sc = wr_pend_r & (wr_addr_r == ADDR_W'(`ADDR_PIN_IRQ_SC));
	wire logic wr_rc = wr_pend_r & (wr_addr_r == ADDR_W'(`ADDR_RESET_CAUSE));
	wire logic ack_write = wr_sc & hwdata[`BIT_PIN_ACK]; // RULE6
	// in level mode the ack loses while the pin still sits asserted
	wire logic ack_clears = ack_write & ~pin_asserted; // RULE7

	irq_rc_pkg::reg8_t sc_view;
	always_comb begin
		sc_view = 8'h00;
		sc_view[`BIT_PULL_DISABLE] = pull_disable_r;
		sc_view[`BIT_EDGE_POL] = edge_polarity_select_r;
		sc_view[`BIT_PIN_EN] = pin_function_enable_r;
		sc_view[`BIT_PIN_FLAG] = pin_event_flag_r; // RULE5
		sc_view[`BIT_PIN_IE] = pin_interrupt_enable_r;
		sc_view[`BIT_DETECT_MODE] = detect_mode_select_r;
	end

	wire logic [31:0] rd_mux = hit_sc_rd ? {24'h000000, sc_view} :
		hit_rc_rd ? {24'h000000, cause_r} : 32'h00000000;

	pin_sync_detect #(
		.SYNC_STAGES(SYNC_STAGES)
	) u_pin (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin_in(irq_pin),
		.enable(pin_function_enable_r),
		.polarity(edge_polarity_select_r),
		.level_mode(detect_mode_select_r),
		.event_pulse(pin_event),
		.asserted_level(pin_asserted)
	);

	reset_cause_capture u_cause (
		.hclk(hclk),
		.hresetn(hresetn),
		.cause_power_on(cause_power_on),
		.cause_pin(cause_pin),
		.cause_watchdog(cause_watchdog),
		.watchdog_enable(watchdog_enable),
		.cause_bad_opcode(cause_bad_opcode),
		.cause_bad_address(cause_bad_address),
		.cause_low_voltage(cause_low_voltage),
		.debug_force_reset_bit(debug_force_reset_bit),
		.cause_r(cause_r)
	);

	// zero wait states: writes land in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
		end else begin
			wr_pend_r <= wr_take;
			wr_addr_r <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata_r <= 32'h00000000;
		else if (rd_take)
			hrdata_r <= rd_mux;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pull_disable_r <= 1'b0;
			edge_polarity_select_r <= 1'b0;
			pin_function_enable_r <= 1'b0;
			pin_interrupt_enable_r <= 1'b0;
			detect_mode_select_r <= 1'b0;
		end else if (wr_sc) begin
			pull_disable_r <= hwdata[`BIT_PULL_DISABLE];
			edge_polarity_select_r <= hwdata[`BIT_EDGE_POL];
			pin_function_enable_r <= hwdata[`BIT_PIN_EN];
			pin_interrupt_enable_r <= hwdata[`BIT_PIN_IE];
			detect_mode_select_r <= hwdata[`BIT_DETECT_MODE];
		end
	end

	// a new event in the ack cycle wins over the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pin_event_flag_r <= 1'b0;
		else if (pin_event)
			pin_event_flag_r <= 1'b1; // RULE5
		else if (ack_clears)
			pin_event_flag_r <= 1'b0; // RULE6
	end

	// cause register contents untouched by writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			restart_r <= 1'b0;
		else
			restart_r <= wr_rc; // RULE12
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign watchdog_restart = restart_r;
	assign pull_enable = pin_function_enable_r & ~pull_disable_r; // RULE1
	assign pull_is_down = pull_enable & edge_polarity_select_r; // RULE3
	assign pin_irq_request = pin_interrupt_enable_r
		& pin_event_flag_r; // RULE8
endmodule

// *** verif/irq_source.sv ***
`timescale 1ns/1ps
module irq_source (
	input wire logic hclk,
	input wire logic want,
	input wire logic slow,
	output logic irq_pin
);
	logic [3:0] dly_r;
	// slow mimics a long rc on the board line
	always_ff @(posedge hclk) dly_r <= {dly_r[2:0], want};
	assign irq_pin = slow ? dly_r[3] : dly_r[0];
endmodule

// *** verif/irq_rc_properties.sv ***
`timescale 1ns/1ps
`include "irq_rc_defines.svh"
module irq_rc_checks #(
	parameter int ADDR_W = 12
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic pull_enable,
	input wire logic pull_is_down,
	input wire logic pin_irq_request,
	input wire logic watchdog_restart,
	input wire logic debug_force_reset_bit
);
	logic wr_dp;
	wire tk = hsel && hready && htrans[1];
	wire rd0 = tk && !hwrite && haddr == ADDR_W'(`ADDR_PIN_IRQ_SC);
	wire rd4 = tk && !hwrite && haddr == ADDR_W'(`ADDR_RESET_CAUSE);
	wire wr4 = tk && hwrite && haddr == ADDR_W'(`ADDR_RESET_CAUSE);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) wr_dp <= 1'b0;
		else wr_dp <= tk && hwrite;
	AST_PULL_DOWN: assert property (pull_is_down |-> pull_enable)
		else $error("pulldown alone");
	AST_PULL_CHG: assert property (
		!$stable(pull_enable) |-> $past(wr_dp))
		else $error("pull moved");
	AST_WDR: assert property (wr4 |-> ##2 watchdog_restart)
		else $error("no restart");
	AST_WDR_ONLY: assert property (watchdog_restart |-> $past(wr4, 2))
		else $error("stray restart");
	AST_RSVD: assert property (
		rd4 |=> hrdata[2] == 1'b0 && !hrdata[0])
		else $error("spare bit set");
	AST_ACK_RD: assert property (
		rd0 |=> !hrdata[2])
		else $error("ack reads 1");
	AST_DBG: assert property (debug_force_reset_bit ##1
		(debug_force_reset_bit && rd4) |=> hrdata[7:0] == 8'h00)
		else $error("cause kept");
	AST_REQ_FALL: assert property (
		$fell(pin_irq_request) |-> $past(wr_dp))
		else $error("request dropped");
	cover property (watchdog_restart);
	cover property ($rose(pin_irq_request));
	cover property (pull_is_down);
endmodule
bind ext_irq_and_reset_cause irq_rc_checks #(.ADDR_W(ADDR_W)) irq_rc_checks_inst (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
	.pull_enable, .pull_is_down, .pin_irq_request, .watchdog_restart,
	.debug_force_reset_bit);

// *** verif/ext_irq_and_reset_cause_bench.sv ***
`timescale 1ns/1ps
module ext_irq_and_reset_cause_bench;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, want = 1, slow = 0;
	logic dbg = 0, hready, irq_pin, pull_enable, pull_is_down;
	logic pin_irq_request, watchdog_restart;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata;
	logic [6:0] cause = 7'h00;
	int fails = 0, tests_run = 0;
	always #4 hclk = ~hclk;
	irq_source irq_source_inst (.hclk, .want, .slow, .irq_pin);
	ext_irq_and_reset_cause ext_irq_and_reset_cause_inst (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready, .hreadyout(hready), .hresp(), .hrdata, .irq_pin,
		.pull_enable, .pull_is_down, .pin_irq_request, .watchdog_restart,
		.cause_power_on(cause[6]), .cause_pin(cause[5]),
		.cause_watchdog(cause[4]), .watchdog_enable(cause[3]),
		.cause_bad_opcode(cause[2]), .cause_bad_address(cause[1]),
		.cause_low_voltage(cause[0]), .debug_force_reset_bit(dbg));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wt;
		int n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 40);
		if (hready !== 1'b1) begin
			fails++;
			tally_and_finish();
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wt();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wt();
		q = hrdata[7:0];
	endtask
	task automatic rck(input string n, input logic [11:0] a,
		input logic [7:0] e);
		logic [7:0] q;
		xfer(1'b0, a, 8'h00, q);
		chk(n, e, q);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, a, d, q);
		// register outputs settle one edge after the data phase
		@(posedge hclk);
	endtask
	task automatic pin(input logic v);
		want <= v;
		repeat (10) @(posedge hclk);
	endtask
	task automatic rc(input logic [6:0] c, input logic [7:0] e);
		@(posedge hclk);
		cause <= c;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		cause <= 7'h00;
		rck("cause", 12'h004, e);
	endtask
	task automatic test_cause;
		rc(7'h40, 8'h82);
		rc(7'h01, 8'h02);
		rc(7'h30, 8'h40);
		rc(7'h1e, 8'h38);
		rc(7'h3f, 8'h7a);
		wr(12'h004, 8'hff);
		chk("restart", 8'h01, {7'h0, watchdog_restart});
		rck("kept", 12'h004, 8'h7a);
		dbg <= 1'b1;
		rck("debug", 12'h004, 8'h00);
		dbg <= 1'b0;
		rck("spare", 12'h008, 8'h00);
		$display("cause test done");
	endtask
	task automatic test_pin;
		wr(12'h000, 8'h12);
		chk("no restart", 8'h00, {7'h0, watchdog_restart});
		pin(1'b0);
		rck("fall", 12'h000, 8'h1a);
		chk("req", 8'h01, {7'h0, pin_irq_request});
		wr(12'h000, 8'h12);
		rck("ack zero", 12'h000, 8'h1a);
		wr(12'h000, 8'h16);
		rck("ack", 12'h000, 8'h12);
		pin(1'b1);
		rck("rise", 12'h000, 8'h12);
		wr(12'h000, 8'h02);
		pin(1'b0);
		rck("off", 12'h000, 8'h02);
		slow <= 1'b1;
		wr(12'h000, 8'h33);
		chk("down", 8'h01, {7'h0, pull_is_down});
		pin(1'b1);
		wr(12'h000, 8'h37);
		rck("level", 12'h000, 8'h3b);
		pin(1'b0);
		wr(12'h000, 8'h37);
		wr(12'h000, 8'h32);
		pin(1'b1);
		wr(12'h000, 8'h36);
		rck("edge", 12'h000, 8'h32);
		wr(12'h000, 8'h70);
		chk("pull", 8'h00, {7'h0, pull_enable});
		wr(12'h000, 8'h10);
		chk("up", 8'h00, {7'h0, pull_is_down});
		$display("pin test done");
	endtask
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		test_cause();
		test_pin();
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		tally_and_finish();
	end
endmodule
